/* rofm_pkg.sv */
// shared constants, types and states of the rail override register bank
package rofm_pkg;
   // register offsets on the serial register port
   localparam logic [7:0] OFS_FORCE_LEVEL = 8'hA1;
   localparam logic [7:0] OFS_MASK_FIRST = 8'hA2;
   localparam logic [7:0] OFS_MASK_SECOND = 8'hA3;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // force-on bits of the force/level register
   localparam int POS_LINREG_A3_FORCE = 0;
   localparam int POS_SWITCH_B1_FORCE = 1;
   localparam int POS_SHARED_FORCE = 2;
   localparam int POS_TERM_FORCE = 3;
   // output one level sits here, outputs two to four above it
   localparam int POS_LEVEL_LSB = 4;
   localparam int NUM_OUTPUTS = 4;
   // second mask register: five masks, then three reserved bits
   localparam int MASK_SECOND_USED = 5;
   localparam int POS_RSVD_ZERO = 6;
   localparam int POS_RSVD_ONE = 5;
   localparam logic RSVD_FIXED_VAL = 1'b0;
   localparam logic RSVD_ZERO_RST = 1'b0;
   localparam logic RSVD_ONE_RST = 1'b1;
   localparam logic LEVEL_PG_RST = 1'b0;
   // first mask register is eight rails, second adds five
   localparam int NUM_FAULT_RAILS = 13;
   // rail enable vector indices
   localparam int RAIL_LINREG_A3 = 0;
   localparam int RAIL_SWITCH_B1 = 1;
   localparam int RAIL_SWITCH_B2 = 2;
   localparam int RAIL_TERM = 3;
   localparam int RAIL_LINREG_A1 = 4;
   localparam int NUM_RAILS = 5;
   // disable input indices, bit low means forced off
   localparam int DIS_LINREG_A3 = 0;
   localparam int DIS_SWITCH_B1 = 1;
   localparam int DIS_SHARED = 2;
   localparam int DIS_TERM = 3;
   localparam int NUM_DISABLES = 4;
   // serial framing
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_SEND_BIT = 4'h7;
   localparam logic [7:0] PTR_STEP = 8'h01;
   // how a general output is driven
   typedef enum logic [1:0] {
      ROFM_OUT_PG = 2'h0,
      ROFM_OUT_OD = 2'h1,
      ROFM_OUT_PP = 2'h2
   } rofm_out_mode_t;
   // factory configuration presented to the bank
   typedef struct packed {
      logic [7:0] forceLevelDefault;
      logic [7:0] maskFirstDefault;
      logic [4:0] maskSecondDefault;
      rofm_out_mode_t [3:0] outMode;
      logic sharedIsLinregA1;
   } rofm_otp_t;
   // serial target states
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RECV = 5'h02,
      ST_ACK = 5'h04,
      ST_SEND = 5'h08,
      ST_RACK = 5'h10
   } rofm_state_t;
endpackage

/* rofm_rail_gate.sv */
// one rail enable: disable bit, software force and pin request
`timescale 1ns/10ps
`default_nettype none
module rofm_rail_gate (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic forceOn,
   input wire logic pinRequest,
   input wire logic enableAllowed,
   output logic railOn
);
   // disable dominates, then force, then the pin or power-good request
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         railOn <= 1'b0;
      end else begin
         railOn <= enableAllowed & (forceOn | pinRequest);
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_disable_wins: assert property (
      !enableAllowed |=> !railOn)
      else $error("rail on while disabled");
   a_force_on_rail: assert property (
      (forceOn && enableAllowed) |=> railOn)
      else $error("forced rail not on");
   a_follow_request: assert property (
      (!forceOn && enableAllowed) |=> railOn == $past(pinRequest))
      else $error("rail does not follow request");
endmodule
`default_nettype wire

/* rofm_out_pin.sv */
// one general output pin: software level, open drain or power-good
`timescale 1ns/10ps
`default_nettype none
module rofm_out_pin #(
   parameter bit OD_ONLY = 1'b0 // pin cannot be push-pull
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire rofm_pkg::rofm_out_mode_t mode,
   input wire logic level,
   input wire logic pgGood,
   output logic pinOut,
   output logic pinOeN
);
   // pin stays released in reset; low enable means driving
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pinOut <= 1'b0;
         pinOeN <= 1'b1;
      end else begin
         case (mode)
            rofm_pkg::ROFM_OUT_PP: begin
               // a push-pull request on an open-drain-only pin degrades
               pinOut <= OD_ONLY ? 1'b0 : level;
               pinOeN <= OD_ONLY ? level : 1'b0;
            end
            rofm_pkg::ROFM_OUT_OD: begin
               pinOut <= 1'b0;
               pinOeN <= level;
            end
            default: begin
               // grouping logic owns the pin, level bit unused
               pinOut <= 1'b0;
               pinOeN <= pgGood;
            end
         endcase
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_od_level: assert property (
      mode == rofm_pkg::ROFM_OUT_OD |=> !pinOut && pinOeN == $past(level))
      else $error("open-drain level wrong");
   a_pp_level: assert property (
      (mode == rofm_pkg::ROFM_OUT_PP && !OD_ONLY)
      |=> !pinOeN && pinOut == $past(level))
      else $error("push-pull level wrong");
   a_pg_owns_pin: assert property (
      mode == rofm_pkg::ROFM_OUT_PG |=> pinOeN == $past(pgGood))
      else $error("level bit leaked onto grouped pin");
endmodule
`default_nettype wire

/* rofm_regs.sv */
// rail force-on, output level and fault mask registers with serial port
`timescale 1ns/10ps
`default_nettype none
module rofm_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h5E // arbitrary target address
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire rofm_pkg::rofm_otp_t otpConfig,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   input wire logic [rofm_pkg::NUM_RAILS-1:0] railRequest,
   input wire logic [rofm_pkg::NUM_DISABLES-1:0] railAllowed,
   input wire logic [rofm_pkg::NUM_FAULT_RAILS-1:0] railFault,
   input wire logic [rofm_pkg::NUM_OUTPUTS-1:0] pgTree,
   output logic [rofm_pkg::NUM_OUTPUTS-1:0] outPin,
   output logic [rofm_pkg::NUM_OUTPUTS-1:0] outOeN,
   output logic [rofm_pkg::NUM_RAILS-1:0] railOn,
   output logic shutdownRequest
);
   if (DEV_ADDR == 7'h00) begin : g_bad_addr
      $error("general call address cannot be the target address");
   end

   // pin synchronisers, third stage only for edge detection
   logic sclQ1, sclQ2, sclQ3;
   logic sdaQ1, sdaQ2, sdaQ3;
   logic sclRise, sclFall, startSeen, stopSeen;
   // serial target state
   rofm_pkg::rofm_state_t state;
   logic [3:0] bitCnt; // bits moved in the current byte
   logic [7:0] shiftReg; // byte being received or sent
   logic firstByte; // next byte is the address byte
   logic ptrPhase; // next written byte is the pointer
   logic readMode; // addressed for reading
   logic [7:0] ptr; // register pointer, auto-increments
   // write request handed to the register process
   logic regWrite;
   logic [7:0] wrAddr, wrData;
   // register contents
   logic [7:0] forceLevel; // force-on and output level bits
   logic [7:0] maskFirst; // masks, first rail group
   logic [4:0] maskSecond; // masks, second rail group
   logic rsvdZero, rsvdOne; // writable reserved bits
   logic [7:0] next_forceLevelRst; // reset image of forceLevel
   logic [7:0] readData; // byte at the pointer
   logic [7:0] maskSecondRead; // full view of the second register
   // rail steering vectors
   logic [rofm_pkg::NUM_RAILS-1:0] forceVec, allowVec;
   logic sharedToA1;

   // two flops per pin before any logic looks at it
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sclQ1 <= 1'b1;
         sclQ2 <= 1'b1;
         sclQ3 <= 1'b1;
         sdaQ1 <= 1'b1;
         sdaQ2 <= 1'b1;
         sdaQ3 <= 1'b1;
      end else begin
         sclQ1 <= sclIn;
         sclQ2 <= sclQ1;
         sclQ3 <= sclQ2;
         sdaQ1 <= sdaIn;
         sdaQ2 <= sdaQ1;
         sdaQ3 <= sdaQ2;
      end
   end

   // bus events seen on the synchronised levels
   assign sclRise = sclQ2 & ~sclQ3;
   assign sclFall = ~sclQ2 & sclQ3;
   assign startSeen = sclQ2 & sclQ3 & sdaQ3 & ~sdaQ2;
   assign stopSeen = sclQ2 & sclQ3 & ~sdaQ3 & sdaQ2;

   // second mask register as read back, bit seven fixed
   assign maskSecondRead = {rofm_pkg::RSVD_FIXED_VAL, rsvdZero, rsvdOne,
      maskSecond};

   // read multiplexer, unmapped offsets read as zero
   always_comb begin
      case (ptr)
         rofm_pkg::OFS_FORCE_LEVEL: readData = forceLevel;
         rofm_pkg::OFS_MASK_FIRST: readData = maskFirst;
         rofm_pkg::OFS_MASK_SECOND: readData = maskSecondRead;
         default: readData = rofm_pkg::UNMAPPED_READ;
      endcase
   end

   // serial target: address, pointer, then data with auto-increment
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= rofm_pkg::ST_IDLE;
         bitCnt <= 4'h0;
         shiftReg <= 8'h00;
         firstByte <= 1'b0;
         ptrPhase <= 1'b0;
         readMode <= 1'b0;
         ptr <= 8'h00;
         sdaOut <= 1'b0;
         sdaOeN <= 1'b1;
         regWrite <= 1'b0;
         wrAddr <= 8'h00;
         wrData <= 8'h00;
      end else begin
         regWrite <= 1'b0;
         if (startSeen) begin
            // start or repeated start: always look for the address
            state <= rofm_pkg::ST_RECV;
            bitCnt <= 4'h0;
            firstByte <= 1'b1;
            sdaOeN <= 1'b1;
         end else if (stopSeen) begin
            state <= rofm_pkg::ST_IDLE;
            sdaOeN <= 1'b1;
         end else begin
            case (state)
               rofm_pkg::ST_RECV: begin
                  if (sclRise && bitCnt != rofm_pkg::BITS_PER_BYTE) begin
                     shiftReg <= {shiftReg[6:0], sdaQ2};
                     bitCnt <= bitCnt + 4'h1;
                  end else if (sclFall &&
                        bitCnt == rofm_pkg::BITS_PER_BYTE) begin
                     bitCnt <= 4'h0;
                     if (firstByte) begin
                        // foreign address: stay silent until next start
                        if (shiftReg[7:1] == DEV_ADDR) begin
                           readMode <= shiftReg[0];
                           ptrPhase <= ~shiftReg[0];
                           firstByte <= 1'b0;
                           state <= rofm_pkg::ST_ACK;
                           sdaOeN <= 1'b0;
                        end else begin
                           state <= rofm_pkg::ST_IDLE;
                        end
                     end else if (ptrPhase) begin
                        ptr <= shiftReg;
                        ptrPhase <= 1'b0;
                        state <= rofm_pkg::ST_ACK;
                        sdaOeN <= 1'b0;
                     end else begin
                        // data byte, stored one cycle later
                        regWrite <= 1'b1;
                        wrAddr <= ptr;
                        wrData <= shiftReg;
                        ptr <= ptr + rofm_pkg::PTR_STEP;
                        state <= rofm_pkg::ST_ACK;
                        sdaOeN <= 1'b0;
                     end
                  end
               end
               rofm_pkg::ST_ACK, rofm_pkg::ST_RACK: begin
                  // controller nack on a read ends the transfer
                  if (state == rofm_pkg::ST_RACK && sclRise && sdaQ2) begin
                     state <= rofm_pkg::ST_IDLE;
                  end else if (sclFall) begin
                     if (readMode) begin
                        state <= rofm_pkg::ST_SEND;
                        shiftReg <= readData;
                        sdaOeN <= readData[7];
                        ptr <= ptr + rofm_pkg::PTR_STEP;
                     end else begin
                        state <= rofm_pkg::ST_RECV;
                        sdaOeN <= 1'b1;
                     end
                     bitCnt <= 4'h0;
                  end
               end
               rofm_pkg::ST_SEND: begin
                  if (sclFall) begin
                     if (bitCnt == rofm_pkg::LAST_SEND_BIT) begin
                        state <= rofm_pkg::ST_RACK;
                        sdaOeN <= 1'b1;
                        bitCnt <= 4'h0;
                     end else begin
                        shiftReg <= {shiftReg[6:0], 1'b0};
                        sdaOeN <= shiftReg[6];
                        bitCnt <= bitCnt + 4'h1;
                     end
                  end
               end
               default: begin
                  sdaOeN <= 1'b1;
               end
            endcase
         end
      end
   end

   // reset image: grouped outputs get a low level bit
   always_comb begin
      next_forceLevelRst = otpConfig.forceLevelDefault;
      for (int i = 0; i < rofm_pkg::NUM_OUTPUTS; i++) begin
         if (otpConfig.outMode[i] == rofm_pkg::ROFM_OUT_PG) begin
            next_forceLevelRst[rofm_pkg::POS_LEVEL_LSB + i] =
               rofm_pkg::LEVEL_PG_RST;
         end
      end
   end

   // register file: factory defaults on reset, byte writes after
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         forceLevel <= next_forceLevelRst;
         maskFirst <= otpConfig.maskFirstDefault;
         maskSecond <= otpConfig.maskSecondDefault;
         rsvdZero <= rofm_pkg::RSVD_ZERO_RST;
         rsvdOne <= rofm_pkg::RSVD_ONE_RST;
      end else if (regWrite) begin
         case (wrAddr)
            rofm_pkg::OFS_FORCE_LEVEL: forceLevel <= wrData;
            rofm_pkg::OFS_MASK_FIRST: maskFirst <= wrData;
            rofm_pkg::OFS_MASK_SECOND: begin
               // bit seven is not stored, so writes to it vanish
               maskSecond <= wrData[rofm_pkg::MASK_SECOND_USED-1:0];
               rsvdZero <= wrData[rofm_pkg::POS_RSVD_ZERO];
               rsvdOne <= wrData[rofm_pkg::POS_RSVD_ONE];
            end
            default: begin
               // unmapped offsets drop the write
            end
         endcase
      end
   end

   // shutdown only for faults whose mask bit is clear
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         shutdownRequest <= 1'b0;
      end else begin
         shutdownRequest <= |(railFault & ~{maskSecond, maskFirst});
      end
   end

   // shared force bit goes to one rail, the other only follows its pin
   assign sharedToA1 = otpConfig.sharedIsLinregA1;
   always_comb begin
      forceVec = '0;
      allowVec = '1;
      forceVec[rofm_pkg::RAIL_LINREG_A3] =
         forceLevel[rofm_pkg::POS_LINREG_A3_FORCE];
      allowVec[rofm_pkg::RAIL_LINREG_A3] =
         railAllowed[rofm_pkg::DIS_LINREG_A3];
      forceVec[rofm_pkg::RAIL_SWITCH_B1] =
         forceLevel[rofm_pkg::POS_SWITCH_B1_FORCE];
      allowVec[rofm_pkg::RAIL_SWITCH_B1] =
         railAllowed[rofm_pkg::DIS_SWITCH_B1];
      forceVec[rofm_pkg::RAIL_TERM] =
         forceLevel[rofm_pkg::POS_TERM_FORCE];
      allowVec[rofm_pkg::RAIL_TERM] = railAllowed[rofm_pkg::DIS_TERM];
      if (sharedToA1) begin
         forceVec[rofm_pkg::RAIL_LINREG_A1] =
            forceLevel[rofm_pkg::POS_SHARED_FORCE];
         allowVec[rofm_pkg::RAIL_LINREG_A1] =
            railAllowed[rofm_pkg::DIS_SHARED];
      end else begin
         forceVec[rofm_pkg::RAIL_SWITCH_B2] =
            forceLevel[rofm_pkg::POS_SHARED_FORCE];
         allowVec[rofm_pkg::RAIL_SWITCH_B2] =
            railAllowed[rofm_pkg::DIS_SHARED];
      end
   end

   // one enable gate per rail
   for (genvar r = 0; r < rofm_pkg::NUM_RAILS; r++) begin : g_rail
      rofm_rail_gate i_rofm_rail_gate (
         .clk_sys(clk_sys),
         .reset(reset),
         .forceOn(forceVec[r]),
         .pinRequest(railRequest[r]),
         .enableAllowed(allowVec[r]),
         .railOn(railOn[r])
      );
   end

   // one driver per general output; output four is open drain only
   for (genvar p = 0; p < rofm_pkg::NUM_OUTPUTS; p++) begin : g_pin
      rofm_out_pin #(
         .OD_ONLY(p == rofm_pkg::NUM_OUTPUTS - 1)
      ) i_rofm_out_pin (
         .clk_sys(clk_sys),
         .reset(reset),
         .mode(otpConfig.outMode[p]),
         .level(forceLevel[rofm_pkg::POS_LEVEL_LSB + p]),
         .pgGood(pgTree[p]),
         .pinOut(outPin[p]),
         .pinOeN(outOeN[p])
      );
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_mask_gates_shutdown: assert property (
      ##1 shutdownRequest ==
         $past(|(railFault & ~{maskSecond, maskFirst})))
      else $error("shutdown does not match unmasked faults");
   a_mask_first_write: assert property (
      (regWrite && wrAddr == rofm_pkg::OFS_MASK_FIRST)
      |=> maskFirst == $past(wrData))
      else $error("first mask write lost");
   a_mask_second_write: assert property (
      (regWrite && wrAddr == rofm_pkg::OFS_MASK_SECOND)
      |=> maskSecond == $past(wrData[4:0]) && rsvdOne == $past(wrData[5]))
      else $error("second mask write lost");
   a_fixed_bit_seven: assert property (
      ((state == rofm_pkg::ST_ACK || state == rofm_pkg::ST_RACK) &&
       readMode && sclFall && !startSeen && !stopSeen &&
       ptr == rofm_pkg::OFS_MASK_SECOND)
      |=> sdaOeN == rofm_pkg::RSVD_FIXED_VAL)
      else $error("read-only bit seven not sent as fixed value");
   a_grouped_level_low: assert property (
      $fell(reset) && otpConfig.outMode[0] == rofm_pkg::ROFM_OUT_PG
      |-> !forceLevel[rofm_pkg::POS_LEVEL_LSB])
      else $error("grouped output level not reset low");
   a_shared_force_route: assert property (
      (forceLevel[rofm_pkg::POS_SHARED_FORCE] && sharedToA1 &&
       railAllowed[rofm_pkg::DIS_SHARED]) |=> railOn[rofm_pkg::RAIL_LINREG_A1])
      else $error("shared force missed selected rail");
endmodule
`default_nettype wire

/* rofm_host_model.sv */
// i2c controller model that reaches the register bank's serial port
`timescale 1ns/10ps
`default_nettype none
module rofm_host_model (
   input wire logic clk_sys,
   input wire logic sdaLine,
   output logic sclOut,
   output logic hostOeN
);
   // idle bus: clock stands high, data released to the pull-up
   initial begin
      sclOut = 1'b1;
      hostOeN = 1'b1;
   end
   // whole system clock cycles, phases kept at four or more
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // start or repeated start: data falls while clock high
   task automatic start();
      tick(4);
      hostOeN <= 1'b1;
      tick(4);
      sclOut <= 1'b1;
      tick(8);
      hostOeN <= 1'b0;
      tick(8);
      sclOut <= 1'b0;
   endtask
   // stop: data rises while clock high, then bus idles
   task automatic stop();
      tick(4);
      hostOeN <= 1'b0;
      tick(4);
      sclOut <= 1'b1;
      tick(8);
      hostOeN <= 1'b1;
      tick(8);
   endtask
   // one bit out, data only moves while clock low
   task automatic bitOut(input logic b);
      tick(4);
      hostOeN <= b;
      tick(4);
      sclOut <= 1'b1;
      tick(8);
      sclOut <= 1'b0;
   endtask
   // one bit in, sampled late in the high phase where it is settled
   task automatic bitIn(output logic b);
      tick(4);
      hostOeN <= 1'b1;
      tick(4);
      sclOut <= 1'b1;
      tick(7);
      b = sdaLine;
      tick(1);
      sclOut <= 1'b0;
   endtask
   // byte out msb first, then the target's acknowledge
   task automatic byteOut(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bitOut(d[i]);
      bitIn(a);
      ack = ~a;
   endtask
   // byte in msb first, then our ack or nack
   task automatic byteIn(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bitIn(d[i]);
      bitOut(last);
   endtask
   // pointer write then one data byte
   task automatic writeReg(input logic [6:0] addr, input logic [7:0] ofs,
         input logic [7:0] d, output logic ok);
      logic a0, a1, a2;
      start();
      byteOut({addr, 1'b0}, a0);
      byteOut(ofs, a1);
      byteOut(d, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask
   // pointer write, repeated start, one byte read with nack
   task automatic readReg(input logic [6:0] addr, input logic [7:0] ofs,
         output logic [7:0] d, output logic ok);
      logic a0, a1, a2;
      start();
      byteOut({addr, 1'b0}, a0);
      byteOut(ofs, a1);
      start();
      byteOut({addr, 1'b1}, a2);
      byteIn(1'b1, d);
      stop();
      ok = a0 & a1 & a2;
   endtask
endmodule
`default_nettype wire

/* rofm_regs_tb_top.sv */
// self-checking bench for the rail override register bank
`timescale 1ns/10ps
`default_nettype none
module rofm_regs_tb_top;
   localparam logic [6:0] ADDR = 7'h5E; // arbitrary target address
   localparam logic [7:0] LVL_DEF = 8'hF5; // factory force/level value
   localparam logic [7:0] M1_DEF = 8'h3C; // factory first masks
   localparam logic [4:0] M2_DEF = 5'h12; // factory second masks
   logic clk_sys;
   logic reset;
   rofm_pkg::rofm_otp_t otpConfig;
   logic sclLine;
   logic hostOeN;
   logic sdaOut;
   logic sdaOeN;
   logic [4:0] railRequest;
   logic [3:0] railAllowed;
   logic [12:0] railFault;
   logic [3:0] pgTree;
   logic [3:0] outPin;
   logic [3:0] outOeN;
   logic [4:0] railOn;
   logic shutdownRequest;
   int n_errors;
   int num_checks;
   int cycles;
   wire logic sdaLine;
   // open-drain data line, pull-up wins when nobody pulls low
   assign sdaLine = hostOeN & (sdaOeN | sdaOut);
   rofm_regs #(.DEV_ADDR(ADDR)) i_rofm_regs (.clk_sys(clk_sys),
      .reset(reset), .otpConfig(otpConfig), .sclIn(sclLine),
      .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
      .railRequest(railRequest), .railAllowed(railAllowed),
      .railFault(railFault), .pgTree(pgTree), .outPin(outPin),
      .outOeN(outOeN), .railOn(railOn),
      .shutdownRequest(shutdownRequest));
   rofm_host_model i_rofm_host_model (.clk_sys(clk_sys),
      .sdaLine(sdaLine), .sclOut(sclLine), .hostOeN(hostOeN));
   // 25 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // hang guard, well above the expected run
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_errors++;
         $display("Error at %0t: run did not finish", $time);
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // register byte compare
   task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: register %h, expected %h", $time, got, exp);
      end
   endtask
   // port vector compare
   task automatic chkVec(input logic [12:0] got, input logic [12:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: port %h, expected %h", $time, got, exp);
      end
   endtask
   // register access through the serial port, ack always expected
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      logic ok;
      i_rofm_host_model.writeReg(ADDR, ofs, d, ok);
      chkVec({12'h0, ok}, 13'h1);
   endtask
   task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
      logic ok;
      i_rofm_host_model.readReg(ADDR, ofs, d, ok);
      chkVec({12'h0, ok}, 13'h1);
   endtask
   // let registered outputs land, then sample mid-cycle
   task automatic settle();
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   // synchronous reset, four cycles, synchroniser given time after
   task automatic doReset();
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   // rail enables: disable beats force, force beats request
   function automatic logic [4:0] expRails(input logic [3:0] f,
         input logic [4:0] r, input logic [3:0] a, input logic sel);
      logic [4:0] e;
      e = r;
      e[0] = a[0] & (f[0] | r[0]);
      e[1] = a[1] & (f[1] | r[1]);
      e[3] = a[3] & (f[3] | r[3]);
      // shared force and disable reach only the selected rail
      if (sel) e[4] = a[2] & (f[2] | r[4]);
      else e[2] = a[2] & (f[2] | r[2]);
      return e;
   endfunction
   // factory defaults after reset, grouped level bit cleared
   task automatic testResetValues();
      logic [7:0] d;
      rd(8'hA1, d);
      chkByte(d, LVL_DEF & 8'hEF);
      rd(8'hA2, d);
      chkByte(d, M1_DEF);
      rd(8'hA3, d);
      chkByte(d, {3'h1, M2_DEF});
   endtask
   // each force bit against every disable and request corner
   task automatic testRails();
      logic [12:0] g, x;
      for (int f = 0; f < 4; f++) begin
         wr(8'hA1, 8'h01 << f);
         for (int c = 0; c < 4; c++) begin
            @(posedge clk_sys);
            railAllowed <= c[0] ? ~(4'h1 << f) : 4'hF;
            railRequest <= c[1] ? 5'h1F : 5'h00;
            settle();
            x = {8'h0, expRails(4'h1 << f, railRequest, railAllowed,
               otpConfig.sharedIsLinregA1)};
            g = {8'h0, railOn};
            chkVec(g, x);
         end
      end
   endtask
   // levels low then high, grouped pin fed the opposite level
   task automatic testOutputs();
      logic [12:0] g, x;
      for (int lv = 0; lv < 2; lv++) begin
         wr(8'hA1, lv[0] ? 8'hF0 : 8'h00);
         @(posedge clk_sys);
         pgTree <= lv[0] ? 4'h0 : 4'hF;
         settle();
         g = {9'h0, outOeN};
         x = {9'h0, lv[0], 1'b0, lv[0], ~lv[0]};
         chkVec(g, x);
         chkVec({9'h0, outPin}, {9'h0, 1'b0, lv[0], 2'h0});
      end
   endtask
   // masks written, then each rail faulted alone
   task automatic testFaults();
      logic [7:0] d;
      logic [12:0] m, g, x;
      m = {5'h0A, 8'h55};
      wr(8'hA2, m[7:0]);
      wr(8'hA3, {3'h5, m[12:8]});
      rd(8'hA3, d);
      chkByte(d, {3'h1, m[12:8]});
      for (int i = 0; i < 13; i++) begin
         @(posedge clk_sys);
         railFault <= 13'h1 << i;
         settle();
         g = {12'h0, shutdownRequest};
         x = {12'h0, ~m[i]};
         chkVec(g, x);
      end
      @(posedge clk_sys);
      railFault <= 13'h0;
   endtask
   // foreign address ignored, unmapped offset reads zero
   task automatic testRefusals();
      logic [7:0] d;
      logic ok;
      i_rofm_host_model.writeReg(ADDR ^ 7'h01, 8'hA2, 8'hFF, ok);
      chkVec({12'h0, ok}, 13'h0);
      rd(8'hA2, d);
      chkByte(d, 8'h55);
      rd(8'hA4, d);
      chkByte(d, rofm_pkg::UNMAPPED_READ);
      // after a stop the port lets the data line go
      chkVec({11'h0, sdaOut, sdaOeN}, 13'h1);
   endtask
   // main sequence, shared rail choice switched just before the second reset
   initial begin
      n_errors = 0;
      num_checks = 0;
      cycles = 0;
      reset = 1'b1;
      otpConfig.forceLevelDefault = LVL_DEF;
      otpConfig.maskFirstDefault = M1_DEF;
      otpConfig.maskSecondDefault = M2_DEF;
      otpConfig.outMode[0] = rofm_pkg::ROFM_OUT_PG;
      otpConfig.outMode[1] = rofm_pkg::ROFM_OUT_OD;
      otpConfig.outMode[2] = rofm_pkg::ROFM_OUT_PP;
      otpConfig.outMode[3] = rofm_pkg::ROFM_OUT_OD;
      otpConfig.sharedIsLinregA1 = 1'b0;
      railRequest = 5'h00;
      railAllowed = 4'hF;
      railFault = 13'h0;
      pgTree = 4'h0;
      doReset();
      testResetValues();
      testRails();
      @(posedge clk_sys);
      otpConfig.sharedIsLinregA1 <= 1'b1;
      doReset();
      testRails();
      testOutputs();
      testFaults();
      testRefusals();
      tally_and_finish();
   end
endmodule
`default_nettype wire
